// >>> acq_seq_cfg.svh
// Constants of the acquisition sequencer: register map, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ACQ_SEQ_CFG_SVH
`define ACQ_SEQ_CFG_SVH

`define ACQ_ADDR_W 4
`define ACQ_DATA_W 8

`define ACQ_OFF_CFG0 4'h0
`define ACQ_OFF_STAGE 4'h1
`define ACQ_OFF_OFF2 4'h2
`define ACQ_OFF_GAIN3 4'h3
`define ACQ_OFF_OFF3 4'h4
`define ACQ_OFF_CTRL 4'h5
`define ACQ_OFF_STAT 4'h6
`define ACQ_OFF_RES_LO 4'h7
`define ACQ_OFF_RES_HI 4'h8

`define ACQ_CFG0_START 7
`define ACQ_CFG0_NELC_MSB 6
`define ACQ_CFG0_NELC_LSB 5
`define ACQ_CFG0_OSR_MSB 4
`define ACQ_CFG0_OSR_LSB 2
`define ACQ_CFG0_FIN_MSB 1
`define ACQ_CFG0_FIN_LSB 0
`define ACQ_STAGE_EN_MSB 3
`define ACQ_STAGE_EN_LSB 0
`define ACQ_STAGE_EN_ADC 0
`define ACQ_STAGE_G1 4
`define ACQ_STAGE_G2_MSB 6
`define ACQ_STAGE_G2_LSB 5
`define ACQ_CTRL_CONTINUOUS_CONVERSION_BIT 0
`define ACQ_CTRL_DEF 1
`define ACQ_STAT_BUSY 0
`define ACQ_STAT_DONE 1

`define ACQ_RST_BYTE 8'h00
`define ACQ_RST_WORD 16'h0000

`define ACQ_RATE_DIV4 16'h0004
`define ACQ_RATE_DIV8 16'h0008
`define ACQ_RATE_DIV32 16'h0020
`define ACQ_CLK_HZ 200000000
`define ACQ_LOW_RATE_HZ 8000
`define ACQ_LOW_RATE_DIV (`ACQ_CLK_HZ / `ACQ_LOW_RATE_HZ)

`define ACQ_INIT_CYCLES 3'h2
`define ACQ_TERM_CYCLES 3'h2
`define ACQ_RES_BASE 5'h06
`define ACQ_RES_MAX 5'h10
`define ACQ_SCALE_BASE 4'hc
`define ACQ_SAT_POS 16'h7fff
`define ACQ_SAT_NEG 16'h8000

`endif

// >>> acq_seq_pkg.sv
// Types shared by the acquisition sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package acq_seq_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ARM,
    SEQ_INIT,
    SEQ_ELEM,
    SEQ_FINAL,
    SEQ_TERM
  } seq_state_e;

  typedef struct packed {
    logic [3:0] enable;
    logic first_stage_gain_sel;
    logic [1:0] second_stage_gain_sel;
    logic [3:0] second_stage_offset_sel;
    logic [6:0] third_stage_gain_sel;
    logic [6:0] third_stage_offset_sel;
  } stage_ctrl_s;

  typedef struct packed {
    logic [1:0] elementary_count_sel;
    logic [2:0] oversampling_sel;
    logic [1:0] sampling_rate_sel;
  } conv_cfg_s;

endpackage

// >>> pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pin toggles slower than a few clock periods.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change only counts once the second and third stage agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_o[i] <= s2_reg[i];
        end
      end
    end
  end
endmodule

// >>> sample_tick_gen.sv
// Sampling-period tick from the RC-based clock, rate picked by a 2-bit select.
// Assumes clk_i is the RC-based clock; tick is one cycle wide.
`timescale 1ns/1ps
`include "acq_seq_cfg.svh"
module sample_tick_gen #(
  parameter logic [15:0] LOW_DIV = 16'(`ACQ_LOW_RATE_DIV)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [1:0] rate_sel_i,
  output logic tick_o
);
  logic [15:0] cnt_reg;
  logic [15:0] limit;

  always_comb begin
    case (rate_sel_i)
      2'h0: limit = `ACQ_RATE_DIV4;
      2'h1: limit = `ACQ_RATE_DIV8;
      2'h2: limit = `ACQ_RATE_DIV32;
      default: limit = LOW_DIV;
    endcase
  end

  // Held in reset while the converter is off, so no ticks burn power
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_reg >= limit - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> acq_seq.sv
// Acquisition chain control: stage enables, gain/offset words and the
// incremental conversion sequencer with averaging and result register.
// Assumes the modulator bit arrives asynchronously on mod_bit_i and that
// the analog chain obeys stage_ctrl_o, offset_pol_o and integ_rst_o.
`timescale 1ns/1ps
`include "acq_seq_cfg.svh"

module acq_seq #(
  parameter logic [15:0] LOW_RATE_DIV = 16'(`ACQ_LOW_RATE_DIV)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`ACQ_ADDR_W-1:0] addr_i,
  input wire logic [`ACQ_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`ACQ_DATA_W-1:0] rdata_o,
  input wire logic mod_bit_i,
  output acq_seq_pkg::stage_ctrl_s stage_ctrl_o,
  output logic sample_o,
  output logic integ_rst_o,
  output logic offset_pol_o,
  output logic busy_o,
  output logic result_valid_o
);
  acq_seq_pkg::seq_state_e state_reg;
  acq_seq_pkg::stage_ctrl_s stage_reg;
  acq_seq_pkg::conv_cfg_s cfg_reg;
  acq_seq_pkg::conv_cfg_s run_cfg_reg;
  logic continuous_conversion_bit_reg;
  logic req_reg;
  logic done_reg;
  logic [15:0] result_reg;
  logic [10:0] period_cnt_reg;
  logic [3:0] elem_cnt_reg;
  logic [2:0] gap_cnt_reg;
  logic signed [14:0] acc_reg;
  logic mod_level;
  logic tick;
  logic adc_on;
  logic wr_cfg0;
  logic wr_ctrl;
  logic wr_stat;
  logic elem_last_period;
  logic elem_last;
  logic finish;
  logic [10:0] osr_val;
  logic [3:0] nelc_val;
  logic [4:0] res_bits;
  logic [3:0] shift_amt;
  logic signed [26:0] scaled;
  logic [15:0] res_mask;
  logic [15:0] result_next;

  assign adc_on = stage_reg.enable[`ACQ_STAGE_EN_ADC];
  assign wr_cfg0 = wr_i && (addr_i == `ACQ_OFF_CFG0);
  assign wr_ctrl = wr_i && (addr_i == `ACQ_OFF_CTRL);
  assign wr_stat = wr_i && (addr_i == `ACQ_OFF_STAT);

  pin_sync #(
    .W(1)
  ) u_mod_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(mod_bit_i),
    .level_o(mod_level)
  );

  // Divider runs only with the converter enabled; restarts phase on enable
  sample_tick_gen #(
    .LOW_DIV(LOW_RATE_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(adc_on),
    .rate_sel_i(busy_o ? run_cfg_reg.sampling_rate_sel : cfg_reg.sampling_rate_sel),
    .tick_o(tick)
  );

  // Stage control words drive the analog chain straight from flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage_reg <= '0;
    end else if (wr_i) begin
      case (addr_i)
        `ACQ_OFF_STAGE: begin
          stage_reg.enable <= wdata_i[`ACQ_STAGE_EN_MSB:`ACQ_STAGE_EN_LSB];
          stage_reg.first_stage_gain_sel <= wdata_i[`ACQ_STAGE_G1];
          stage_reg.second_stage_gain_sel <=
            wdata_i[`ACQ_STAGE_G2_MSB:`ACQ_STAGE_G2_LSB];
        end
        `ACQ_OFF_OFF2: begin
          stage_reg.second_stage_offset_sel <= wdata_i[3:0];
        end
        `ACQ_OFF_GAIN3: begin
          stage_reg.third_stage_gain_sel <= wdata_i[6:0];
        end
        `ACQ_OFF_OFF3: begin
          stage_reg.third_stage_offset_sel <= wdata_i[6:0];
        end
        default: begin
          stage_reg <= stage_reg;
        end
      endcase
    end
  end

  assign stage_ctrl_o = stage_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_reg <= '0;
    end else if (wr_cfg0) begin
      cfg_reg.elementary_count_sel <=
        wdata_i[`ACQ_CFG0_NELC_MSB:`ACQ_CFG0_NELC_LSB];
      cfg_reg.oversampling_sel <= wdata_i[`ACQ_CFG0_OSR_MSB:`ACQ_CFG0_OSR_LSB];
      cfg_reg.sampling_rate_sel <= wdata_i[`ACQ_CFG0_FIN_MSB:`ACQ_CFG0_FIN_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      continuous_conversion_bit_reg <= 1'b0;
    end else if (wr_ctrl) begin
      continuous_conversion_bit_reg <= wdata_i[`ACQ_CTRL_CONTINUOUS_CONVERSION_BIT];
    end
  end

  // Pending request: start or default bit; taken on the SEQ_ARM tick that starts the sequence
  always_ff @(posedge clk_i) begin
    if (srst_i || !adc_on) begin
      req_reg <= 1'b0;
    end else if ((wr_cfg0 && wdata_i[`ACQ_CFG0_START]) ||
                 (wr_ctrl && wdata_i[`ACQ_CTRL_DEF])) begin
      req_reg <= 1'b1;
    end else if (state_reg == acq_seq_pkg::SEQ_ARM && tick) begin
      req_reg <= 1'b0;
    end
  end

  // Latched at start so CFG0 writes cannot disturb a running sequence
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_cfg_reg <= '0;
    end else if (state_reg == acq_seq_pkg::SEQ_ARM && tick) begin
      run_cfg_reg <= cfg_reg;
    end
  end

  assign osr_val = 11'h008 << run_cfg_reg.oversampling_sel;
  assign nelc_val = 4'h1 << run_cfg_reg.elementary_count_sel;
  assign elem_last_period = tick && (period_cnt_reg == osr_val);
  assign elem_last = elem_last_period && (elem_cnt_reg == nelc_val - 4'h1);
  assign finish = (state_reg == acq_seq_pkg::SEQ_TERM) && (gap_cnt_reg == 3'h0);

  always_ff @(posedge clk_i) begin
    if (srst_i || !adc_on) begin
      state_reg <= acq_seq_pkg::SEQ_IDLE;
    end else begin
      case (state_reg)
        acq_seq_pkg::SEQ_IDLE: begin
          if (req_reg || continuous_conversion_bit_reg) begin
            state_reg <= acq_seq_pkg::SEQ_ARM;
          end
        end
        acq_seq_pkg::SEQ_ARM: begin
          if (tick) begin
            state_reg <= acq_seq_pkg::SEQ_INIT;
          end
        end
        acq_seq_pkg::SEQ_INIT: begin
          if (gap_cnt_reg == 3'h0) begin
            state_reg <= acq_seq_pkg::SEQ_ELEM;
          end
        end
        acq_seq_pkg::SEQ_ELEM: begin
          if (elem_last) begin
            state_reg <= acq_seq_pkg::SEQ_FINAL;
          end
        end
        acq_seq_pkg::SEQ_FINAL: begin
          if (tick) begin
            state_reg <= acq_seq_pkg::SEQ_TERM;
          end
        end
        acq_seq_pkg::SEQ_TERM: begin
          if (finish) begin
            if (continuous_conversion_bit_reg || req_reg) begin
              state_reg <= acq_seq_pkg::SEQ_ARM;
            end else begin
              state_reg <= acq_seq_pkg::SEQ_IDLE;
            end
          end
        end
        default: begin
          state_reg <= acq_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Extra clock cycles around the sampling periods
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gap_cnt_reg <= 3'h0;
    end else if (state_reg == acq_seq_pkg::SEQ_ARM) begin
      gap_cnt_reg <= `ACQ_INIT_CYCLES - 3'h1;
    end else if (state_reg == acq_seq_pkg::SEQ_FINAL) begin
      gap_cnt_reg <= `ACQ_TERM_CYCLES - 3'h1;
    end else if (gap_cnt_reg != 3'h0) begin
      gap_cnt_reg <= gap_cnt_reg - 3'h1;
    end
  end

  // Period counter up to 1024, conversion counter up to 8
  always_ff @(posedge clk_i) begin
    if (srst_i || state_reg != acq_seq_pkg::SEQ_ELEM) begin
      period_cnt_reg <= 11'h000;
      elem_cnt_reg <= 4'h0;
    end else if (elem_last_period) begin
      period_cnt_reg <= 11'h000;
      elem_cnt_reg <= elem_cnt_reg + 4'h1;
    end else if (tick) begin
      period_cnt_reg <= period_cnt_reg + 11'h001;
    end
  end

  // Polarity flips at each conversion boundary so offset terms subtract
  always_ff @(posedge clk_i) begin
    if (srst_i || state_reg == acq_seq_pkg::SEQ_IDLE ||
        state_reg == acq_seq_pkg::SEQ_ARM) begin
      offset_pol_o <= 1'b0;
    end else if (state_reg == acq_seq_pkg::SEQ_ELEM && elem_last_period) begin
      offset_pol_o <= ~offset_pol_o;
    end
  end

  // Integrator held clear outside conversions and pulsed between them
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      integ_rst_o <= 1'b1;
    end else begin
      integ_rst_o <= (state_reg != acq_seq_pkg::SEQ_ELEM) ||
                     elem_last_period;
    end
  end

  // An abort drops a pending pulse, so no sample lands outside a run
  always_ff @(posedge clk_i) begin
    if (srst_i || !adc_on) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= tick && (state_reg == acq_seq_pkg::SEQ_ELEM ||
                           state_reg == acq_seq_pkg::SEQ_FINAL);
    end
  end

  // Sign-corrected bit count over all conversions; mean taken by shifting
  always_ff @(posedge clk_i) begin
    if (srst_i || state_reg == acq_seq_pkg::SEQ_INIT) begin
      acc_reg <= 15'sh0000;
    end else if (state_reg == acq_seq_pkg::SEQ_ELEM && tick) begin
      if (mod_level ^ offset_pol_o) begin
        acc_reg <= acc_reg + 15'sh0001;
      end else begin
        acc_reg <= acc_reg - 15'sh0001;
      end
    end
  end

  always_comb begin
    res_bits = `ACQ_RES_BASE + {1'b0, run_cfg_reg.oversampling_sel, 1'b0} +
               {3'h0, run_cfg_reg.elementary_count_sel};
    if (res_bits > `ACQ_RES_MAX) begin
      res_bits = `ACQ_RES_MAX;
    end
    res_mask = 16'hffff << (`ACQ_RES_MAX - res_bits);
    shift_amt = `ACQ_SCALE_BASE - {1'b0, run_cfg_reg.oversampling_sel} -
                {2'h0, run_cfg_reg.elementary_count_sel};
    // Scale to full 16-bit span and divide by the count in one shift
    scaled = 27'(acc_reg) <<< shift_amt;
    if (scaled > 27'sh0007fff) begin
      result_next = `ACQ_SAT_POS;
    end else if (scaled < -27'sh0008000) begin
      result_next = `ACQ_SAT_NEG;
    end else begin
      result_next = scaled[15:0] & res_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_reg <= `ACQ_RST_WORD;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= finish;
      if (finish) begin
        result_reg <= result_next;
      end
    end
  end

  // Busy from the sampling tick that actually starts the sequence
  always_ff @(posedge clk_i) begin
    if (srst_i || !adc_on) begin
      busy_o <= 1'b0;
    end else if (state_reg == acq_seq_pkg::SEQ_ARM && tick) begin
      busy_o <= 1'b1;
    end else if (finish) begin
      busy_o <= 1'b0;
    end
  end

  // Done is sticky; a completion in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (wr_stat && wdata_i[`ACQ_STAT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= `ACQ_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `ACQ_OFF_CFG0: rdata_o <= {1'b0, cfg_reg};
        `ACQ_OFF_STAGE: rdata_o <= {1'b0, stage_reg.second_stage_gain_sel,
                                    stage_reg.first_stage_gain_sel,
                                    stage_reg.enable};
        `ACQ_OFF_OFF2: rdata_o <= {4'h0, stage_reg.second_stage_offset_sel};
        `ACQ_OFF_GAIN3: rdata_o <= {1'b0, stage_reg.third_stage_gain_sel};
        `ACQ_OFF_OFF3: rdata_o <= {1'b0, stage_reg.third_stage_offset_sel};
        `ACQ_OFF_CTRL: rdata_o <= {7'h00, continuous_conversion_bit_reg};
        `ACQ_OFF_STAT: rdata_o <= {6'h00, done_reg, busy_o};
        `ACQ_OFF_RES_LO: rdata_o <= result_reg[7:0];
        `ACQ_OFF_RES_HI: rdata_o <= result_reg[15:8];
        default: rdata_o <= `ACQ_RST_BYTE;
      endcase
    end else begin
      rdata_o <= `ACQ_RST_BYTE;
    end
  end
endmodule

// >>> acq_seq_sva.sv
// Port checker for the acquisition sequencer.
// Assumes one clock domain and the sequencer's register map.
`timescale 1ns/1ps
`include "acq_seq_cfg.svh"
module acq_seq_sva #(
  parameter logic [15:0] LOW_RATE_DIV = 16'h0010
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`ACQ_ADDR_W-1:0] addr_i,
  input wire logic [`ACQ_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`ACQ_DATA_W-1:0] rdata_o,
  input wire logic mod_bit_i,
  input wire acq_seq_pkg::stage_ctrl_s stage_ctrl_o,
  input wire logic sample_o,
  input wire logic integ_rst_o,
  input wire logic offset_pol_o,
  input wire logic busy_o,
  input wire logic result_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_stage_write;
    $past(wr_i) && $past(addr_i) == `ACQ_OFF_STAGE |-> {stage_ctrl_o.second_stage_gain_sel,
      stage_ctrl_o.first_stage_gain_sel, stage_ctrl_o.enable} == $past(wdata_i[6:0]);
  endproperty
  a_stage_write: assert property (p_stage_write)
    else $error("stage word differs from write");

  property p_offset2_write;
    $past(wr_i) && $past(addr_i) == `ACQ_OFF_OFF2 |->
      stage_ctrl_o.second_stage_offset_sel == $past(wdata_i[3:0]);
  endproperty
  a_offset2_write: assert property (p_offset2_write)
    else $error("second offset differs from write");

  property p_gain3_write;
    $past(wr_i) && $past(addr_i) == `ACQ_OFF_GAIN3 |->
      stage_ctrl_o.third_stage_gain_sel == $past(wdata_i[6:0]);
  endproperty
  a_gain3_write: assert property (p_gain3_write)
    else $error("third gain differs from write");

  property p_offset3_write;
    $past(wr_i) && $past(addr_i) == `ACQ_OFF_OFF3 |->
      stage_ctrl_o.third_stage_offset_sel == $past(wdata_i[6:0]);
  endproperty
  a_offset3_write: assert property (p_offset3_write)
    else $error("third offset differs from write");

  // One cycle of grace: the abort clears busy one clock after the enable register lands
  property p_busy_needs_enable;
    !stage_ctrl_o.enable[0] |=> !busy_o;
  endproperty
  a_busy_needs_enable: assert property (p_busy_needs_enable)
    else $error("busy while converter disabled");

  property p_sample_in_run;
    sample_o |-> busy_o;
  endproperty
  a_sample_in_run: assert property (p_sample_in_run)
    else $error("sample pulse outside a conversion");

  property p_sample_gap;
    sample_o |=> !sample_o [*3];
  endproperty
  a_sample_gap: assert property (p_sample_gap)
    else $error("sample pulses closer than four clocks");

  property p_pol_start;
    $rose(busy_o) |-> !offset_pol_o;
  endproperty
  a_pol_start: assert property (p_pol_start)
    else $error("offset polarity not cleared at start");

  property p_init_hold;
    $rose(busy_o) |-> (integ_rst_o && !sample_o) [*2];
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("initial clocks missing");

  property p_valid_after_end;
    result_valid_o |-> (!busy_o && $past(busy_o, 2)) ##1 !result_valid_o;
  endproperty
  a_valid_after_end: assert property (p_valid_after_end)
    else $error("result pulse not tied to end of run");
endmodule

// >>> mod_bit_model.sv
// Modulator bit source standing in for the analog chain.
// Assumes sample_i pulses once per sampling period.
`timescale 1ns/1ps
module mod_bit_model (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [1:0] mode_i,
  output logic mod_bit_o
);
  // Mode 0 holds low, 1 holds high, 2 flips per sample like a mid-scale input
  initial mod_bit_o = 1'b0;
  always @(posedge clk_i) begin
    if (mode_i == 2'h2) begin
      if (sample_i) begin
        mod_bit_o <= !mod_bit_o;
      end
    end else begin
      mod_bit_o <= mode_i[0];
    end
  end
endmodule

// >>> acq_seq_bench.sv
// Self-checking bench for the acquisition sequencer with a modulator model.
// Assumes the sequencer's register map and timing; 200 MHz clock.
`timescale 1ns/1ps
`include "acq_seq_cfg.svh"
module acq_seq_bench;
  typedef struct {int samples; int toggles; int period;} conv_note_t;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic mod_bit_i;
  acq_seq_pkg::stage_ctrl_s stage_ctrl_o;
  logic sample_o, integ_rst_o, offset_pol_o, busy_o, result_valid_o;
  logic [1:0] mode = 2'h2;
  logic rd_d = 1'b0;
  logic busy_d = 1'b0;
  logic pol_d = 1'b0;
  logic [15:0] rd_e;
  logic [15:0] rd_q[$];
  conv_note_t conv_q[$];
  conv_note_t note;
  conv_note_t got;
  int failures = 0;
  int n_compared = 0;
  int n_samp = 0, n_tog = 0, gap = 0, last_gap = 0, n_valid = 0;
  logic [7:0] rnd;
  logic [3:0] a4;

  // Short low-rate divider keeps the slowest setting cheap to simulate
  acq_seq #(.LOW_RATE_DIV(16'h0010)) dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mod_bit_i(mod_bit_i),
    .stage_ctrl_o(stage_ctrl_o), .sample_o(sample_o), .integ_rst_o(integ_rst_o),
    .offset_pol_o(offset_pol_o), .busy_o(busy_o), .result_valid_o(result_valid_o));
  mod_bit_model model (.clk_i(clk_i), .sample_i(sample_o), .mode_i(mode),
    .mod_bit_o(mod_bit_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] mask,
      input logic [7:0] seen);
    n_compared++;
    if ((seen & mask) !== (exp & mask)) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp & mask, seen & mask);
    end
  endtask

  task automatic check_count(input string name, input int exp, input int seen);
    n_compared++;
    if (seen != exp) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  // Strobes stay up so calls can run back to back; idle() drops them
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic [7:0] exp, input logic [7:0] mask);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    if (!w) begin
      rd_q.push_back({exp, mask});
    end
    @(posedge clk_i);
  endtask

  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask

  // Flags are looked at on the falling edge, clear of the launching edge
  task automatic wait_level(input logic lvl, input int limit);
    for (int i = 0; i < limit; i++) begin
      @(negedge clk_i);
      if (busy_o === lvl) break;
    end
    if (busy_o !== lvl) begin
      failures++;
      complete_run();
    end
    @(posedge clk_i);
  endtask

  task automatic expect_conv(input logic [7:0] cfg, input int period);
    note.samples = (1 << cfg[6:5]) * ((1 << (3 + cfg[4:2])) + 1) + 1;
    note.toggles = 1 << cfg[6:5];
    note.period = period;
    conv_q.push_back(note);
  endtask

  task automatic wait_conv(input int period);
    wait_level(1'b1, period + 8);
    wait_level(1'b0, 40000);
  endtask

  task automatic convert(input logic [7:0] cfg, input int period);
    expect_conv(cfg, period);
    bus(1'b1, `ACQ_OFF_CFG0, cfg | 8'h80, 8'h00, 8'h00);
    idle(1);
    wait_conv(period);
  endtask

  always @(posedge clk_i) begin
    if (rd_d && rd_q.size() > 0) begin
      rd_e = rd_q.pop_front();
      check_byte("read data", rd_e[15:8], rd_e[7:0], rdata_o);
    end
    if (busy_o && !busy_d) begin
      n_samp = 0;
      n_tog = 0;
    end
    if (busy_o && sample_o) n_samp++;
    if (result_valid_o === 1'b1) n_valid++;
    if (busy_o && busy_d && offset_pol_o !== pol_d) n_tog++;
    gap++;
    if (sample_o) begin
      last_gap = gap;
      gap = 0;
    end
    // Aborted or unrequested runs carry no note and are not scored here
    if (!busy_o && busy_d && conv_q.size() > 0) begin
      got = conv_q.pop_front();
      check_count("sample count", got.samples, n_samp);
      check_count("polarity flips", got.toggles, n_tog);
      check_count("sample period", got.period, last_gap);
    end
    busy_d = busy_o;
    pol_d = offset_pol_o;
    rd_d = rd_i;
  end

  initial begin
    void'($urandom(24));
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 16; a++) begin
      bus(1'b0, a[3:0], 8'h00, 8'h00, 8'hff);
    end
    for (int k = 0; k < 16; k++) begin
      rnd = 8'($urandom());
      a4 = 4'(1 + k % 4);
      bus(1'b1, a4, rnd, 8'h00, 8'h00);
      bus(1'b0, a4, 8'h00, rnd, (a4 == `ACQ_OFF_OFF2) ? 8'h0f : 8'h7f);
    end
    bus(1'b1, 4'hc, 8'hff, 8'h00, 8'h00);
    bus(1'b0, 4'hc, 8'h00, 8'h00, 8'hff);
    bus(1'b1, `ACQ_OFF_STAGE, 8'h0e, 8'h00, 8'h00);
    bus(1'b1, `ACQ_OFF_CFG0, 8'h80, 8'h00, 8'h00);
    idle(40);
    bus(1'b1, `ACQ_OFF_STAGE, 8'h0f, 8'h00, 8'h00);
    idle(40);
    bus(1'b0, `ACQ_OFF_STAT, 8'h00, 8'h00, 8'h01);
    idle(1);
    for (int r = 0; r < 4; r++) begin
      convert(8'(r), (r == 0) ? 4 : (r == 1) ? 8 : (r == 2) ? 32 : 16);
    end
    for (int o = 0; o < 8; o++) begin
      convert(8'(o << 2), 4);
    end
    for (int n = 0; n < 4; n++) begin
      convert(8'(n << 5), 4);
    end
    convert(8'h7c, 4);
    mode <= 2'h1;
    convert(8'h00, 4);
    bus(1'b0, `ACQ_OFF_RES_HI, 8'h00, 8'h70, 8'hf0);
    bus(1'b0, `ACQ_OFF_STAT, 8'h00, 8'h02, 8'h03);
    bus(1'b1, `ACQ_OFF_STAT, 8'h02, 8'h00, 8'h00);
    bus(1'b0, `ACQ_OFF_STAT, 8'h00, 8'h00, 8'h03);
    mode <= 2'h0;
    convert(8'h00, 4);
    bus(1'b0, `ACQ_OFF_RES_HI, 8'h00, 8'h80, 8'hf0);
    mode <= 2'h1;
    // Two conversions in one run with opposite offset sign: a steady input averages to near zero
    convert(8'h20, 4);
    bus(1'b0, `ACQ_OFF_RES_HI, 8'h00, 8'h00, 8'hf0);
    expect_conv(8'h20, 4);
    bus(1'b1, `ACQ_OFF_CTRL, 8'h02, 8'h00, 8'h00);
    idle(1);
    wait_conv(4);
    expect_conv(8'h20, 4);
    expect_conv(8'h20, 4);
    bus(1'b1, `ACQ_OFF_CTRL, 8'h01, 8'h00, 8'h00);
    idle(1);
    wait_conv(4);
    wait_conv(4);
    bus(1'b1, `ACQ_OFF_STAGE, 8'h00, 8'h00, 8'h00);
    bus(1'b1, `ACQ_OFF_CTRL, 8'h00, 8'h00, 8'h00);
    bus(1'b1, `ACQ_OFF_STAGE, 8'h0f, 8'h00, 8'h00);
    idle(40);
    bus(1'b1, `ACQ_OFF_CFG0, 8'h9c, 8'h00, 8'h00);
    idle(1);
    wait_level(1'b1, 12);
    idle(20);
    bus(1'b1, `ACQ_OFF_STAGE, 8'h00, 8'h00, 8'h00);
    idle(2);
    bus(1'b0, `ACQ_OFF_STAT, 8'h00, 8'h00, 8'h01);
    idle(4);
    // Aborted runs end without a result, so only finished runs pulse
    check_count("result pulses", 23, n_valid);
    complete_run();
  end
endmodule

bind acq_seq acq_seq_sva #(.LOW_RATE_DIV(LOW_RATE_DIV)) u_sva (.clk_i(clk_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .mod_bit_i(mod_bit_i), .stage_ctrl_o(stage_ctrl_o), .sample_o(sample_o),
  .integ_rst_o(integ_rst_o), .offset_pol_o(offset_pol_o), .busy_o(busy_o),
  .result_valid_o(result_valid_o));
